// File: hw/pdmap_params.svh
/*
 * Constants of the holding-register map and process-data mapper.
 * Assumes a request framer that has already decoded the serial frames.
 */
`ifndef PDMAP_PARAMS_SVH
`define PDMAP_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_WPD_BASE 16'h0000
`define REG_RPD_BASE 16'h1000
`define REG_FAULT    16'h5005
`define REG_UNIT     16'h5100
`define REG_OFFL     16'h5101
`define REG_WCNT     16'h5102
`define REG_RCNT     16'h5103
`define REG_NODE     16'h5200
`define REG_COMM     16'h5201

// ----------------------------------------------------------------
// Register values and resets
// ----------------------------------------------------------------
`define UNIT_8       16'h0004
`define UNIT_16      16'h0005
`define OFFL_CLEAR   16'h0000
`define OFFL_KEEP    16'h0001
`define CNT_RESET    16'h0000
`define SW_RESET     16'h0000

// ----------------------------------------------------------------
// Module states, function codes, exception codes
// ----------------------------------------------------------------
`define ST_SETUP     3'h0
`define ST_ACTIVE    3'h4
`define FC_RD_HOLD   8'h03
`define FC_RD_INPUT  8'h04
`define FC_WR_SINGLE 8'h06
`define FC_WR_MULTI  8'h10
`define FC_RD_WR     8'h17
`define FC_MOD_CMD   8'h46
`define EXC_ILL_FUNC 8'h01
`define EXC_NONE     8'h00
`define EXC_FIRST    8'h01
`define EXC_LAST     8'h0c

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define PD_WORDS     4
`define PD_IDX_W     2
`define FIFO_DEPTH   8

`endif

// File: hw/pdmap_pkg.sv
/*
 * Types shared by the mapper and its buffer.
 * Assumes pdmap_params.svh is on the include path.
 */
package pdmap_pkg;

    // ----------------------------------------------------------------
    // Request and answer of one register access, module command, process-data words
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] wdata;
    } req_s;

    typedef struct packed {
        logic        valid;
        logic        exc;
        logic [7:0]  exc_code;
        logic [15:0] rdata;
    } rsp_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } cmd_s;

    typedef logic [3:0][15:0] pd_words_t;

endpackage

// File: hw/pdata_fifo.sv
/*
 * Word FIFO between the network receive side and the read staging area.
 * Assumes a single clock; in_ready and out_valid are registered flags.
 */
`timescale 1ns/1ps
`default_nettype none

module pdata_fifo
    import pdmap_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)(
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        room;
        logic                        avail;
    } fifo_s;

    fifo_s st;
    fifo_s next_st;
    logic  push;
    logic  pop;

    assign push      = in_valid && st.room;
    assign pop       = out_ready && st.avail;
    assign in_ready  = st.room;
    assign out_valid = st.avail;
    assign out_data  = st.mem[st.rp];

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop)
            next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.room  = (next_st.cnt != (AW+1)'(DEPTH));
        next_st.avail = (next_st.cnt != '0);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st      <= '0;
            st.room <= 1'b1;
        end
        else
            st <= next_st;
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
        st.cnt <= (AW+1)'(DEPTH)) else $error("fifo count past depth");

endmodule

`default_nettype wire

// File: hw/modbus_param_and_pdata_map.sv
/*
 * Holding-register map and process-data mapper of the serial slave.
 * Assumes an upstream framer that turns each frame into one-register requests
 * and a network side that streams process-data words in wire byte order.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdmap_params.svh"

module modbus_param_and_pdata_map
    import pdmap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire req_s        req,
    output var  rsp_s        rsp,
    output var  cmd_s        cmd,
    input  wire logic [2:0]  mod_state,
    input  wire logic [7:0]  fault_code,
    input  wire logic        net_big_endian,
    input  wire logic [15:0] net_max_wr,
    input  wire logic [15:0] net_max_rd,
    input  wire logic        net_valid,
    output var  logic        net_ready,
    input  wire logic [15:0] net_data,
    output var  logic        tx_valid,
    output var  logic [63:0] tx_data,
    output var  logic        pd_type_16,
    output var  logic [15:0] wr_param_count,
    output var  logic [15:0] rd_param_count,
    output var  logic [15:0] node_address,
    output var  logic [15:0] comm_setting
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                 unit16;
        logic                 offline_keep;
        logic [15:0]          wr_cnt;
        logic [15:0]          rd_cnt;
        logic [15:0]          node;
        logic [15:0]          comm;
        logic [7:0]           fault;
        pd_words_t            wpd;
        pd_words_t            stage;
        pd_words_t            snap;
        logic [`PD_IDX_W-1:0] stage_wp;
        logic                 stage_full;
        logic                 prev_setup;
        rsp_s                 rsp;
        cmd_s                 cmd;
        logic                 tx_valid;
        logic [63:0]          tx_data;
    } map_s;

    map_s        st;
    map_s        next_st;
    logic        fifo_valid;
    logic [15:0] fifo_data;
    logic        drain;
    logic        in_setup;
    logic        online;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // The swap is its own inverse, so one function serves both directions.
    function automatic logic [15:0] to_net(input logic [15:0] w, input logic u16,
                                           input logic big);
        to_net = (u16 && big) ? w : {w[7:0], w[15:8]};
    endfunction

    function automatic logic in_area(input logic [15:0] a, input logic [15:0] base);
        in_area = (a[15:`PD_IDX_W] == base[15:`PD_IDX_W]);
    endfunction

    function automatic logic func_ok(input logic [7:0] f);
        func_ok = (f == `FC_RD_HOLD) || (f == `FC_RD_INPUT) || (f == `FC_WR_SINGLE) ||
                  (f == `FC_WR_MULTI) || (f == `FC_RD_WR) || (f == `FC_MOD_CMD);
    endfunction

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    // The staging area stops draining once it holds a whole frame, so, when online or when offline with the keep action, a host
    // that never reads the first word lets the buffer fill and stalls the net.
    pdata_fifo #(
        .WIDTH (16),
        .DEPTH (`FIFO_DEPTH)
    ) pdata_fifo_inst (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (net_valid),
        .in_ready  (net_ready),
        .in_data   (net_data),
        .out_valid (fifo_valid),
        .out_ready (drain),
        .out_data  (fifo_data)
    );

    assign drain    = !st.stage_full;
    assign in_setup = (mod_state == `ST_SETUP);
    assign online   = (mod_state == `ST_ACTIVE);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.rsp = '0;
        next_st.cmd.valid = 1'b0;
        next_st.tx_valid = 1'b0;
        next_st.prev_setup = in_setup;
        if (fault_code >= `EXC_FIRST && fault_code <= `EXC_LAST)
            next_st.fault = fault_code;
        else
            next_st.fault = `EXC_NONE;

        if (st.prev_setup && !in_setup)
        begin
            if (st.wr_cnt > net_max_wr)
                next_st.wr_cnt = net_max_wr;
            if (st.rd_cnt > net_max_rd)
                next_st.rd_cnt = net_max_rd;
        end

        if (drain && fifo_valid)
        begin
            next_st.stage[st.stage_wp] = to_net(fifo_data, st.unit16, net_big_endian);
            next_st.stage_wp = st.stage_wp + 1'b1;
            if (&st.stage_wp)
                next_st.stage_full = 1'b1;
        end

        if (req.valid)
        begin
            next_st.rsp.valid = 1'b1;
            if (!func_ok(req.func))
            begin
                next_st.rsp.exc = 1'b1;
                next_st.rsp.exc_code = `EXC_ILL_FUNC;
            end
            else if (req.func == `FC_MOD_CMD)
            begin
                next_st.cmd.valid = req.write;
                next_st.cmd.data = req.wdata;
            end
            else if (req.write)
            begin
                // Writes never raise an error, whatever they hit.
                if (in_area(req.addr, `REG_WPD_BASE))
                begin
                    next_st.wpd[req.addr[`PD_IDX_W-1:0]] = req.wdata;
                    next_st.tx_valid = &req.addr[`PD_IDX_W-1:0];
                end
                else if (req.addr == `REG_NODE)
                    next_st.node = req.wdata;
                else if (req.addr == `REG_COMM)
                    next_st.comm = req.wdata;
                else if (in_setup)
                begin
                    case (req.addr)
                        `REG_UNIT:
                        begin
                            if (req.wdata == `UNIT_16)
                                next_st.unit16 = 1'b1;
                            else if (req.wdata == `UNIT_8)
                                next_st.unit16 = 1'b0;
                        end
                        `REG_OFFL:
                        begin
                            if (req.wdata == `OFFL_KEEP)
                                next_st.offline_keep = 1'b1;
                            else if (req.wdata == `OFFL_CLEAR)
                                next_st.offline_keep = 1'b0;
                        end
                        `REG_WCNT: next_st.wr_cnt = req.wdata;
                        `REG_RCNT: next_st.rd_cnt = req.wdata;
                        default: next_st.rsp.exc = 1'b0;
                    endcase
                end
            end
            else
            begin
                if (in_area(req.addr, `REG_WPD_BASE))
                    next_st.rsp.rdata = st.wpd[req.addr[`PD_IDX_W-1:0]];
                else if (req.addr == `REG_RPD_BASE)
                begin
                    next_st.snap = st.stage;
                    next_st.stage_full = 1'b0;
                    next_st.rsp.rdata = st.stage[0];
                end
                else if (in_area(req.addr, `REG_RPD_BASE))
                    next_st.rsp.rdata = st.snap[req.addr[`PD_IDX_W-1:0]];
                else
                begin
                    case (req.addr)
                        `REG_FAULT: next_st.rsp.rdata = {8'h00, st.fault};
                        `REG_UNIT:  next_st.rsp.rdata = st.unit16 ? `UNIT_16 : `UNIT_8;
                        `REG_OFFL:  next_st.rsp.rdata = st.offline_keep ? `OFFL_KEEP : `OFFL_CLEAR;
                        `REG_WCNT:  next_st.rsp.rdata = st.wr_cnt;
                        `REG_RCNT:  next_st.rsp.rdata = st.rd_cnt;
                        `REG_NODE:  next_st.rsp.rdata = st.node;
                        `REG_COMM:  next_st.rsp.rdata = st.comm;
                        default:    next_st.rsp.rdata = 16'h0000;
                    endcase
                end
            end
        end

        if (next_st.tx_valid)
        begin
            // Nothing goes out before the last word lands, keeping the frame whole.
            next_st.tx_data = {to_net(next_st.wpd[0], st.unit16, net_big_endian),
                               to_net(next_st.wpd[1], st.unit16, net_big_endian),
                               to_net(next_st.wpd[2], st.unit16, net_big_endian),
                               to_net(next_st.wpd[3], st.unit16, net_big_endian)};
        end

        if (!online && !st.offline_keep)
        begin
            next_st.stage = '0;
            next_st.snap = '0;
            next_st.stage_wp = '0;
            next_st.stage_full = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.unit16 <= 1'b0;
            st.offline_keep <= 1'b1;
            st.wr_cnt <= `CNT_RESET;
            st.rd_cnt <= `CNT_RESET;
            st.node <= `SW_RESET;
            st.comm <= `SW_RESET;
            st.prev_setup <= 1'b1;
        end
        else
            st <= next_st;
    end

    assign rsp            = st.rsp;
    assign cmd            = st.cmd;
    assign tx_valid       = st.tx_valid;
    assign tx_data        = st.tx_data;
    assign pd_type_16     = st.unit16;
    assign wr_param_count = st.wr_cnt;
    assign rd_param_count = st.rd_cnt;
    assign node_address   = st.node;
    assign comm_setting   = st.comm;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    unit_lock_a: assert property (
        req.valid && req.write && func_ok(req.func) && req.func != `FC_MOD_CMD &&
        req.addr == `REG_UNIT && !in_setup |=> $stable(st.unit16))
        else $error("unit type changed outside setup");
    unit_set_a: assert property (
        req.valid && req.write && req.func == `FC_WR_SINGLE && req.addr == `REG_UNIT &&
        req.wdata == `UNIT_16 && in_setup |=> pd_type_16 ##1 $stable(pd_type_16) [*1])
        else $error("unit type write to 16-bit not taken");
    bad_value_a: assert property (
        req.valid && req.write && req.func == `FC_WR_SINGLE && req.addr == `REG_OFFL &&
        req.wdata != `OFFL_KEEP && req.wdata != `OFFL_CLEAR |=> $stable(st.offline_keep))
        else $error("unlisted offline value taken");
    offline_clear_a: assert property (
        !online && !st.offline_keep |=> st.snap == '0 && !st.stage_full)
        else $error("read data kept while offline with clear action");
    count_clamp_a: assert property (
        st.prev_setup && !in_setup |=> wr_param_count <= $past(net_max_wr) &&
        rd_param_count <= $past(net_max_rd))
        else $error("parameter count not clamped");
    undef_zero_a: assert property (
        req.valid && !req.write && req.func == `FC_RD_HOLD && req.addr == 16'h7fff |=>
        rsp.valid && !rsp.exc && rsp.rdata == 16'h0000)
        else $error("undefined read not zero");
    write_quiet_a: assert property (
        req.valid && req.write && func_ok(req.func) |=> rsp.valid && !rsp.exc)
        else $error("write answered with exception");
    ro_write_a: assert property (
        req.valid && req.write && req.func == `FC_WR_MULTI && req.addr == `REG_WCNT &&
        !in_setup && !st.prev_setup |=> $stable(wr_param_count) && !rsp.exc)
        else $error("read-only count changed by write");
    bad_func_a: assert property (
        req.valid && !func_ok(req.func) |=> rsp.exc && rsp.exc_code == `EXC_ILL_FUNC)
        else $error("unknown function not refused");
    snap_take_a: assert property (
        req.valid && !req.write && req.func == `FC_RD_HOLD && req.addr == `REG_RPD_BASE &&
        (online || st.offline_keep) |=> st.snap == $past(st.stage))
        else $error("snapshot not taken on first word read");
    cmd_pulse_a: assert property (
        req.valid && req.write && req.func == `FC_MOD_CMD |=>
        cmd.valid && cmd.data == $past(req.wdata))
        else $error("module command not passed on");
    node_take_a: assert property (
        req.valid && req.write && func_ok(req.func) && req.func != `FC_MOD_CMD &&
        req.addr == `REG_NODE |=> node_address == $past(req.wdata))
        else $error("node address write not taken");
    fault_code_a: assert property (
        fault_code >= `EXC_FIRST && fault_code <= `EXC_LAST |=> st.fault == $past(fault_code))
        else $error("fault cause not shown as exception code");

    snap_cov: cover property (req.valid && req.addr == `REG_RPD_BASE ##1 rsp.valid);
    tx_cov: cover property (tx_valid && pd_type_16);
    stall_cov: cover property (!net_ready ##1 net_ready);
    cmd_cov: cover property (cmd.valid);

endmodule

`default_nettype wire

// File: dv/net_partner.sv
/*
 * Network-side partner of the mapper: streams receive words into its buffer.
 * Assumes the bench calls send on the shared clock and owns nothing else here.
 */
`timescale 1ns/1ps
`default_nettype none

module net_partner (
    input  wire logic        clk,
    input  wire logic        net_ready,
    output var  logic        net_valid,
    output var  logic [15:0] net_data
);
    initial
    begin
        net_valid = 1'b0;
        net_data  = 16'ha5a5;
    end

    // The word stands until an edge sees ready high; after that the bus shows
    // the inverse so a stale read cannot pass for a good one.
    task automatic send(input logic [15:0] w);
        logic rdy;
        @(negedge clk);
        net_valid = 1'b1;
        net_data  = w;
        do
        begin
            rdy = net_ready;
            @(posedge clk);
        end
        while (rdy !== 1'b1);
        @(negedge clk);
        net_valid = 1'b0;
        net_data  = ~w;
    endtask
endmodule

`default_nettype wire

// File: dv/tb_modbus_param_and_pdata_map.sv
/*
 * Self-checking bench of the register map and process-data mapper.
 * Assumes one-register requests from a framer and a network partner model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdmap_params.svh"

module tb_modbus_param_and_pdata_map
    import pdmap_pkg::*;
;
    logic        clk            = 1'b0;
    logic        sys_rst        = 1'b1;
    req_s        req            = '0;
    rsp_s        rsp;
    rsp_s        got;
    cmd_s        cmd;
    logic [2:0]  mod_state      = `ST_SETUP;
    logic [7:0]  fault_code     = 8'h00;
    logic        net_big_endian = 1'b1;
    logic [15:0] net_max_wr     = 16'h0010;
    logic [15:0] net_max_rd     = 16'h0008;
    logic        net_valid;
    logic        net_ready;
    logic        tx_valid;
    logic        pd_type_16;
    logic [15:0] net_data;
    logic [15:0] wr_param_count;
    logic [15:0] rd_param_count;
    logic [15:0] node_address;
    logic [15:0] comm_setting;
    logic [63:0] tx_data;
    logic [15:0] pd [0:11];
    int          fail_count     = 0;
    int          comparisons    = 0;
    int          cycles         = 0;

    always #2 clk = ~clk;

    modbus_param_and_pdata_map modbus_param_and_pdata_map_inst (
        .clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .cmd(cmd),
        .mod_state(mod_state), .fault_code(fault_code), .net_big_endian(net_big_endian),
        .net_max_wr(net_max_wr), .net_max_rd(net_max_rd), .net_valid(net_valid),
        .net_ready(net_ready), .net_data(net_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .pd_type_16(pd_type_16), .wr_param_count(wr_param_count), .rd_param_count(rd_param_count),
        .node_address(node_address), .comm_setting(comm_setting)
    );

    net_partner net_partner_inst (
        .clk(clk), .net_ready(net_ready), .net_valid(net_valid), .net_data(net_data)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // The answer is registered on the taking edge itself, so it is read at the next falling edge.
    task automatic access(input logic wr, input logic [7:0] fn, input logic [15:0] a,
                          input logic [15:0] d, input logic [7:0] exc_exp);
        @(negedge clk);
        req = '{1'b1, wr, fn, a, d};
        @(negedge clk);
        req.valid = 1'b0;
        got = rsp;
        check("rsp_valid", rsp.valid, 1'b1);
        check("rsp_exc", rsp.exc, exc_exp != 8'h00);
        if (exc_exp != 8'h00)
            check("exc_code", rsp.exc_code, exc_exp);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        access(1'b1, `FC_WR_SINGLE, a, d, 8'h00);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        access(1'b0, `FC_RD_HOLD, a, 16'h0000, 8'h00);
        check($sformatf("reg_%h", a), got.rdata, e);
    endtask

    function automatic logic [15:0] conv(input logic [15:0] w, input logic u16, input logic big);
        return (u16 && big) ? w : {w[7:0], w[15:8]};
    endfunction

    task automatic tx_frame(input logic u16);
        for (int i = 0; i < 4; i++)
            wr(16'(i), pd[i]);
        check("tx_valid", tx_valid, 1'b1);
        check("tx_data", tx_data, {conv(pd[0], u16, net_big_endian), conv(pd[1], u16, net_big_endian),
                                   conv(pd[2], u16, net_big_endian), conv(pd[3], u16, net_big_endian)});
    endtask

    task automatic rx_batch(input int base, input logic u16);
        for (int i = 0; i < 4; i++)
            rd(`REG_RPD_BASE + 16'(i), conv(pd[base + i], u16, net_big_endian));
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 12; i++)
            pd[i] = 16'h3c81 + 16'(i) * 16'h1111;
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rd(`REG_UNIT, `UNIT_8);
        rd(`REG_OFFL, `OFFL_KEEP);
        check("wr_cnt", wr_param_count, `CNT_RESET);
        check("pd_type", pd_type_16, 1'b0);
        tx_frame(1'b0);
        net_big_endian = 1'b0;
        tx_frame(1'b0);
        for (int i = 0; i < 4; i++)
            net_partner_inst.send(pd[i]);
        repeat (4) @(negedge clk);
        rx_batch(0, 1'b0);
        wr(`REG_OFFL, `OFFL_CLEAR);
        rd(`REG_OFFL, `OFFL_CLEAR);
        rd(`REG_RPD_BASE, 16'h0000);
        rd(`REG_RPD_BASE + 16'h1, 16'h0000);
        wr(`REG_OFFL, 16'h0002);
        rd(`REG_OFFL, `OFFL_CLEAR);
        wr(`REG_OFFL, `OFFL_KEEP);
        wr(`REG_UNIT, 16'h0007);
        rd(`REG_UNIT, `UNIT_8);
        wr(`REG_UNIT, `UNIT_16);
        rd(`REG_UNIT, `UNIT_16);
        check("pd_type", pd_type_16, 1'b1);
        wr(`REG_WCNT, 16'h0020);
        wr(`REG_RCNT, 16'h0003);
        rd(`REG_WCNT, 16'h0020);
        mod_state = `ST_ACTIVE;
        repeat (3) @(negedge clk);
        check("wr_cnt", wr_param_count, 16'h0010);
        check("rd_cnt", rd_param_count, 16'h0003);
        wr(`REG_UNIT, `UNIT_8);
        access(1'b1, `FC_WR_MULTI, `REG_WCNT, 16'h0001, 8'h00);
        rd(`REG_UNIT, `UNIT_16);
        rd(`REG_WCNT, 16'h0010);
        tx_frame(1'b1);
        net_big_endian = 1'b1;
        tx_frame(1'b1);
        for (int i = 0; i < 12; i++)
            net_partner_inst.send(pd[i]);
        repeat (4) @(negedge clk);
        check("net_ready", net_ready, 1'b0);
        rx_batch(0, 1'b1);
        repeat (4) @(negedge clk);
        rd(`REG_RPD_BASE + 16'h1, pd[1]);
        rx_batch(4, 1'b1);
        repeat (4) @(negedge clk);
        rx_batch(8, 1'b1);
        check("net_ready", net_ready, 1'b1);
        wr(`REG_NODE, 16'h002a);
        access(1'b1, `FC_WR_MULTI, `REG_COMM, 16'h0103, 8'h00);
        check("node", node_address, 16'h002a);
        check("comm", comm_setting, 16'h0103);
        access(1'b0, `FC_RD_INPUT, `REG_COMM, 16'h0000, 8'h00);
        check("fc_input", got.rdata, 16'h0103);
        access(1'b1, `FC_RD_WR, `REG_NODE, 16'h0055, 8'h00);
        access(1'b0, `FC_RD_WR, `REG_NODE, 16'h0000, 8'h00);
        check("fc_rdwr", got.rdata, 16'h0055);
        access(1'b0, 8'h05, `REG_NODE, 16'h0000, `EXC_ILL_FUNC);
        access(1'b1, `FC_MOD_CMD, 16'h0000, 16'h1234, 8'h00);
        check("cmd", {cmd.valid, cmd.data}, {1'b1, 16'h1234});
        rd(16'h7fff, 16'h0000);
        wr(16'h4000, 16'h9999);
        wr(`REG_FAULT, 16'h0001);
        for (int f = 0; f < 14; f++)
        begin
            fault_code = 8'(f);
            rd(`REG_FAULT, (f >= 1 && f <= 12) ? 16'(f) : 16'h0000);
        end
        give_verdict();
    end
endmodule

`default_nettype wire
